// ### odd_ratio_clock_divider.sv
// Notes on behaviour
// R1: Enable sampled synchronously, defaults to asserted
// R2: Enabling waits one rising, one falling edge
// R3: Disabling waits rising edge, output fall, holds low
// R4: Full high pulse completes before gating, except when clear or reset cuts it
// R5: Divider advances on both input edges
// R6: Divide-by-three falls at second cycle falling edge
// R7: Divide-by-five falls at third cycle falling edge
// R8: High time gives half duty on symmetric input
// R9: Ratio select static, changed only during reset
// R10: Clear forces output low, count restarts after
`timescale 1ns/1ns
`default_nettype none
module odd_ratio_clock_divider
    import odd_div_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic divider_clear_n,
    input wire logic clk_in,
    input wire logic out_enable,
    input wire logic ratio_div5,
    output logic clk_out
);
    logic clk_lvl;
    logic clk_prev;
    logic en_lvl;
    logic div5_lvl;
    in_edge_t ev;
    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] next_phase;
    div_state_t state;
    div_state_t next_state;
    gate_state_t gate;
    gate_state_t next_gate;
    logic next_clk_prev;
    logic next_out;
    logic raw;
    logic next_raw;

    // Edges in a period for the selected ratio
    function automatic logic [PHASE_W-1:0] period_edges(input logic div5);
        period_edges = div5 ? DIV5_EDGES : DIV3_EDGES;
    endfunction : period_edges

    // Edges the output stays high for the selected ratio
    function automatic logic [PHASE_W-1:0] high_edges(input logic div5);
        high_edges = div5 ? DIV5_HIGH_EDGES : DIV3_HIGH_EDGES;
    endfunction : high_edges

    // Pin samplers
    pin_sync #(.INIT(CLK_RESET)) u_clk_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin(clk_in),
        .level(clk_lvl)
    );

    pin_sync #(.INIT(ENABLE_RESET)) u_en_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin(out_enable), // R1
        .level(en_lvl)
    );

    pin_sync #(.INIT(RATIO_RESET)) u_ratio_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin(ratio_div5), // R9
        .level(div5_lvl)
    );

    // Both edges of the input clock are events
    always_comb begin
        ev.rise = clk_lvl & ~clk_prev; // R5
        ev.fall = ~clk_lvl & clk_prev; // R5
    end

    // Phase counter: even phases on rising edges, odd on falling edges
    always_comb begin
        next_clk_prev = clk_lvl;
        next_state = state;
        next_phase = phase;
        raw = (state == DIV_RUN) && (phase < high_edges(div5_lvl));
        if (state == DIV_WAIT) begin
            if (ev.rise) begin // R10
                next_state = DIV_RUN;
                next_phase = PHASE_RESET;
            end
        end else if (ev.rise || ev.fall) begin // R5
            if (phase == period_edges(div5_lvl) - 4'h1) begin
                next_phase = PHASE_RESET;
            end else begin
                next_phase = phase + 4'h1;
            end
        end
        // High for phases below the high count: falls at 3 or 5
        next_raw = (next_state == DIV_RUN) &&
                   (next_phase < high_edges(div5_lvl)); // R6 R7 R8
    end

    // Output gate sequencing
    always_comb begin
        next_gate = gate;
        case (gate)
            GATE_OFF: begin
                if (en_lvl && ev.rise) begin // R2
                    next_gate = GATE_ARM;
                end
            end
            GATE_ARM: begin
                if (!en_lvl) begin
                    next_gate = GATE_OFF;
                end else if (ev.fall) begin // R2
                    next_gate = GATE_READY;
                end
            end
            GATE_READY: begin
                if (!en_lvl) begin
                    next_gate = GATE_OFF;
                end else if (next_raw && !raw) begin // R4
                    next_gate = GATE_ON;
                end
            end
            GATE_ON: begin
                if (!en_lvl && ev.rise) begin // R3
                    next_gate = GATE_DRAIN;
                end
            end
            GATE_DRAIN: begin
                if (en_lvl) begin
                    next_gate = GATE_ON;
                end else if (raw && !next_raw) begin // R3 R4
                    next_gate = GATE_OFF;
                end else if (!raw) begin
                    next_gate = GATE_OFF;
                end
            end
            default: begin
                next_gate = GATE_OFF;
            end
        endcase
        // A pulse in progress runs out unless cut by clear or reset; new ones start only when open
        next_out = next_raw &&
                   (clk_out || (!raw && next_gate == GATE_ON)); // R4
    end

    // Input clock history; kept through a clear so no false edge follows it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clk_prev <= CLK_RESET;
        end else begin
            clk_prev <= next_clk_prev;
        end
    end

    // Registers; clear acts at once, system reset on the clock
    always_ff @(posedge sys_clk or negedge divider_clear_n) begin
        if (!divider_clear_n) begin // R10
            state <= DIV_WAIT;
            phase <= PHASE_RESET;
            gate <= GATE_OFF;
            clk_out <= OUT_RESET;
        end else if (!rst_n) begin
            state <= DIV_WAIT;
            phase <= PHASE_RESET;
            gate <= GATE_OFF;
            clk_out <= OUT_RESET;
        end else begin
            state <= next_state;
            phase <= next_phase;
            gate <= next_gate;
            clk_out <= next_out;
        end
    end

    // Output never runs while the gate is closed
    property p_off_low;
        @(posedge sys_clk) disable iff (!rst_n || !divider_clear_n)
        (gate == GATE_OFF) |-> !clk_out;
    endproperty
    a_off_low: assert property (p_off_low) // R1
        else $error("output high while gate closed");

    // Output starts only after the arm sequence
    property p_start_ready;
        @(posedge sys_clk) disable iff (!rst_n || !divider_clear_n)
        $rose(clk_out) |-> $past(gate) inside {GATE_READY, GATE_ON};
    endproperty
    a_start_ready: assert property (p_start_ready) // R2
        else $error("output started without arm sequence");

    // Gate closes only together with an output fall or while low
    property p_stop_on_fall;
        @(posedge sys_clk) disable iff (!rst_n || !divider_clear_n)
        ($past(gate) == GATE_DRAIN && gate == GATE_OFF) |-> !clk_out;
    endproperty
    a_stop_on_fall: assert property (p_stop_on_fall) // R3
        else $error("gate closed with output high");

    // Every high pulse not cut by clear or reset ends at its full length
    property p_full_pulse;
        @(posedge sys_clk) disable iff (!rst_n || !divider_clear_n)
        $fell(clk_out) |-> (phase == high_edges(div5_lvl));
    endproperty
    a_full_pulse: assert property (p_full_pulse) // R4
        else $error("high pulse cut short");

    // Falling input edges also move the phase
    property p_both_edges;
        @(posedge sys_clk) disable iff (!rst_n || !divider_clear_n)
        (state == DIV_RUN && ev.fall) |=> (phase != $past(phase));
    endproperty
    a_both_edges: assert property (p_both_edges) // R5
        else $error("falling edge did not advance divider");

    // Divide by three: fall at phase three
    property p_div3_fall;
        @(posedge sys_clk) disable iff (!rst_n || !divider_clear_n)
        ($fell(clk_out) && !div5_lvl) |-> (phase == DIV3_HIGH_EDGES);
    endproperty
    a_div3_fall: assert property (p_div3_fall) // R6
        else $error("divide by three fall misplaced");

    // Divide by five: fall at phase five
    property p_div5_fall;
        @(posedge sys_clk) disable iff (!rst_n || !divider_clear_n)
        ($fell(clk_out) && div5_lvl) |-> (phase == DIV5_HIGH_EDGES);
    endproperty
    a_div5_fall: assert property (p_div5_fall) // R7
        else $error("divide by five fall misplaced");

    // Rises start a period on a rising input edge
    property p_rise_phase;
        @(posedge sys_clk) disable iff (!rst_n || !divider_clear_n)
        $rose(clk_out) |-> (phase == PHASE_RESET);
    endproperty
    a_rise_phase: assert property (p_rise_phase) // R8
        else $error("output rise not at period start");

    // Reset leaves output low and count cleared
    property p_reset_clear;
        @(posedge sys_clk) disable iff (!divider_clear_n)
        !rst_n |=> (!clk_out && phase == PHASE_RESET && state == DIV_WAIT);
    endproperty
    a_reset_clear: assert property (p_reset_clear) // R10
        else $error("reset did not clear divider");
endmodule : odd_ratio_clock_divider
`default_nettype wire

// ### odd_div_pkg.sv
package odd_div_pkg;

    // Phase counter width; one count per input clock edge
    localparam int PHASE_W = 4;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 4'h0;

    // Input edges per output period and edges the output stays high
    localparam logic [PHASE_W-1:0] DIV3_EDGES = 4'h6;
    localparam logic [PHASE_W-1:0] DIV5_EDGES = 4'ha;
    localparam logic [PHASE_W-1:0] DIV3_HIGH_EDGES = 4'h3;
    localparam logic [PHASE_W-1:0] DIV5_HIGH_EDGES = 4'h5;

    // Values after reset
    localparam logic ENABLE_RESET = 1'b1;
    localparam logic RATIO_RESET = 1'b0;
    localparam logic CLK_RESET = 1'b0;
    localparam logic OUT_RESET = 1'b0;

    // Edges of the sampled input clock seen in one system cycle
    typedef struct packed {
        logic rise;
        logic fall;
    } in_edge_t;

    // Divider run state
    typedef enum logic {
        DIV_WAIT,
        DIV_RUN
    } div_state_t;

    // Output gate state
    typedef enum logic [2:0] {
        GATE_OFF,
        GATE_ARM,
        GATE_READY,
        GATE_ON,
        GATE_DRAIN
    } gate_state_t;

endpackage : odd_div_pkg

// ### pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    // Three stage shift; level follows once stages two and three agree
    always_comb begin
        next_stage = {stage[1:0], pin};
        next_level = level;
        if (stage[1] == stage[2]) begin
            next_level = stage[2];
        end
    end

    // Registers only
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage <= {3{INIT}};
            level <= INIT;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ### clk_src.sv
`timescale 1ns/1ns
`default_nettype none
module clk_src #(
    parameter int HALF = 8
) (
    input wire logic sys_clk,
    input wire logic run,
    output logic clk_in
);
    int cnt = 0;
    initial clk_in = 1'b0;
    // Symmetric input clock; stands low while not running
    always @(posedge sys_clk) begin
        #1;
        if (!run) begin
            cnt = 0;
            clk_in = 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt = 0;
            clk_in = ~clk_in;
        end else begin
            cnt++;
        end
    end
endmodule : clk_src
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t value %0d expected %0d", $time, a, b); end end
module testbench;
    import odd_div_pkg::*;
    localparam int H = 8;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic divider_clear_n = 1'b1;
    logic out_enable = 1'b1;
    logic ratio_div5 = 1'b0;
    logic run = 1'b0;
    logic clk_in;
    logic clk_out;
    int failures = 0;
    int cmp_count = 0;

    always #5 sys_clk = ~sys_clk;

    // Input clock source on the far side
    clk_src #(.HALF(H)) src (.sys_clk(sys_clk), .run(run), .clk_in(clk_in));

    odd_ratio_clock_divider dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .divider_clear_n(divider_clear_n),
        .clk_in(clk_in),
        .out_enable(out_enable),
        .ratio_div5(ratio_div5),
        .clk_out(clk_out)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // Count settled cycles until the output shows the level v
    task automatic wait_out(input logic v, output int n);
        n = 0;
        while (clk_out !== v) begin
            @(negedge sys_clk);
            n++;
            if (n > 400) begin
                failures++;
                $display("ERROR %0t output stuck", $time);
                summarize();
            end
        end
    endtask : wait_out

    // Length of the next full stretch at level v
    task automatic level_len(input logic v, output int n);
        int d;
        wait_out(v, d);
        wait_out(~v, n);
    endtask : level_len

    task automatic do_reset(input logic div5);
        @(posedge sys_clk);
        #1;
        rst_n = 1'b0;
        run = 1'b0;
        ratio_div5 = div5;
        repeat (16) @(posedge sys_clk);
        #1;
        `CHECK(clk_out, 1'b0)
        rst_n = 1'b1;
        run = 1'b1;
    endtask : do_reset

    task automatic test_ratio(input logic div5);
        int n;
        int e;
        do_reset(div5);
        e = (div5 ? 5 : 3) * H;
        level_len(1'b1, n);
        `CHECK(n, e)
        level_len(1'b0, n);
        `CHECK(n, e)
        $display("ratio test done, div5=%0d", div5);
    endtask : test_ratio

    task automatic test_disable();
        int n;
        int hi;
        wait_out(1'b0, n);
        wait_out(1'b1, n);
        @(posedge sys_clk);
        #1;
        out_enable = 1'b0;
        wait_out(1'b0, n);
        `CHECK(n, 3 * H)
        hi = 0;
        repeat (10 * H) begin
            @(negedge sys_clk);
            hi += (clk_out !== 1'b0);
        end
        `CHECK(hi, 0)
        $display("disable test done");
    endtask : test_disable

    task automatic test_enable();
        int d;
        int n;
        @(posedge sys_clk);
        #1;
        out_enable = 1'b1;
        wait_out(1'b1, d);
        `CHECK(d >= H, 1'b1)
        wait_out(1'b0, n);
        `CHECK(n, 3 * H)
        $display("enable test done");
    endtask : test_enable

    task automatic test_clear();
        int n;
        wait_out(1'b1, n);
        @(posedge sys_clk);
        #1;
        divider_clear_n = 1'b0;
        #1;
        `CHECK(clk_out, 1'b0)
        repeat (4) @(posedge sys_clk);
        #1;
        divider_clear_n = 1'b1;
        level_len(1'b1, n);
        `CHECK(n, 3 * H)
        $display("clear test done");
    endtask : test_clear

    // Main sequence
    initial begin
        test_ratio(1'b1);
        test_ratio(1'b0);
        test_disable();
        test_enable();
        test_clear();
        summarize();
    end
endmodule : testbench
`default_nettype wire
